//--- src/wpt_i2c_target.sv
/*
  I2C target and 16-bit command decoder of a nonvolatile digital potentiometer.
  Assumes SCL/SDA arrive asynchronously from an open-drain bus with pull-ups;
  the bench resolves SDA from sdaOe (low while high). EEPROM is modelled by flops.
*/
// How it works
// - Works at 100 and 400 kHz SCL
// - Only seven-bit addresses, no general call
// - Address match acknowledged in ninth clock
// - R/W bit high reads, low writes
// - Nine clocks per byte, SDA moves low
// - Address is one of two build options
// - Sixteen-bit command word, MSB first
// - Bits ten to eight select operation
// - Load command copies data to wiper
// - Smaller variants ignore low data bits
// - Write: address, two acked bytes, stop
// - Further word pairs accepted per transfer
// - Store locks interface, address not acked
// - Readback: command transfer, then two-byte read
// - NACK on first byte stops transmission
// - Each read needs fresh read command
// - EEPROM select: saved wiper or tolerance
// - Software reset reloads wiper from EEPROM
// - Shutdown follows data bit zero
// - Store copies wiper into EEPROM
// - Store lasts 18 ms, locked throughout
// - Power-on preset restores EEPROM into wiper
`timescale 1ns/10ps
`default_nettype none

module wpt_i2c_target #(
  parameter int         POSITIONS = 128,
  parameter bit         ADDR_SEL  = 1'b0,
  parameter int         STORE_CYC = wpt_pkg::STORE_CYC,
  parameter logic [7:0] TOLERANCE = 8'h00  // Arbitrary factory tolerance code
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      wiperSetting,
  output logic            shutdownMode,
  output logic            eepromBusy
);
  // ==========================================================================
  // Local constants and reset synchroniser
  localparam logic [7:0] MASK    = wpt_pkg::wpt_mask(POSITIONS);
  localparam logic [6:0] OWN_ADR = ADDR_SEL ? wpt_pkg::ADDR_OPT1 : wpt_pkg::ADDR_OPT0;

  logic [1:0]          rstPipe_ff;
  logic                rstSync_n;
  wpt_pkg::wpt_state_t s_ff;
  wpt_pkg::wpt_state_t nxt_s;
  logic                sclRise;
  logic                sclFall;
  logic                startCond;
  logic                stopCond;
  logic                sdaS;
  logic                exec;
  logic [2:0]          cmd;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_ff[1];

  // ==========================================================================
  // Bus event detection on the second and third sampling stages
  assign sdaS      = s_ff.sdaP[1];
  assign sclRise   = s_ff.sclP[1] & ~s_ff.sclP[2];
  assign sclFall   = ~s_ff.sclP[1] & s_ff.sclP[2];
  assign startCond = s_ff.sclP[1] & s_ff.sclP[2] & s_ff.sdaP[2] & ~s_ff.sdaP[1];
  assign stopCond  = s_ff.sclP[1] & s_ff.sclP[2] & ~s_ff.sdaP[2] & s_ff.sdaP[1];
  assign cmd       = s_ff.cmdHi[2:0];

  // ==========================================================================
  // Next-state logic
  always_comb begin
    nxt_s        = s_ff;
    exec         = 1'b0;
    nxt_s.sclP   = {s_ff.sclP[1:0], sclIn};
    nxt_s.sdaP   = {s_ff.sdaP[1:0], sdaIn};
    nxt_s.sdaOut = 1'b0;
    if (s_ff.preset) begin
      nxt_s.wiper  = s_ff.eeprom & MASK;
      nxt_s.preset = 1'b0;
    end
    if (s_ff.busyCnt != '0) begin
      nxt_s.busyCnt = s_ff.busyCnt - 1'b1;
    end
    if (s_ff.refreshCnt != '0) begin
      nxt_s.refreshCnt = s_ff.refreshCnt - 1'b1;
      if (s_ff.refreshCnt == wpt_pkg::REF_W'(1)) begin
        nxt_s.wiper = s_ff.eeprom & MASK;
      end
    end
    if (startCond) begin
      nxt_s.phase  = wpt_pkg::ST_ADDR;
      nxt_s.bitCnt = 4'h0;
      nxt_s.sdaOe  = 1'b0;
    end else if (stopCond) begin
      nxt_s.phase = wpt_pkg::ST_IDLE;
      nxt_s.sdaOe = 1'b0;
    end else begin
      unique case (s_ff.phase)
        wpt_pkg::ST_IDLE, wpt_pkg::ST_IGNORE: begin
        end
        wpt_pkg::ST_ADDR, wpt_pkg::ST_RX: begin
          if (sclRise && s_ff.bitCnt < wpt_pkg::BITS_PER_BYTE) begin
            nxt_s.shift  = {s_ff.shift[6:0], sdaS};
            nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
          end else if (sclFall && s_ff.bitCnt == wpt_pkg::BITS_PER_BYTE) begin
            if (s_ff.phase == wpt_pkg::ST_ADDR) begin
              nxt_s.rw = s_ff.shift[0];
              if (s_ff.shift[7:1] == OWN_ADR && s_ff.busyCnt == '0) begin
                nxt_s.phase = wpt_pkg::ST_ADDR_ACK;
                nxt_s.sdaOe = 1'b1;
              end else begin
                nxt_s.phase = wpt_pkg::ST_IGNORE;
              end
            end else begin
              nxt_s.phase   = wpt_pkg::ST_WACK;
              nxt_s.sdaOe   = 1'b1;
              nxt_s.byteIdx = ~s_ff.byteIdx;
              if (!s_ff.byteIdx) begin
                nxt_s.cmdHi = s_ff.shift;
              end else begin
                exec = 1'b1;
              end
            end
          end
        end
        wpt_pkg::ST_ADDR_ACK: begin
          if (sclFall) begin
            nxt_s.bitCnt  = 4'h0;
            nxt_s.byteIdx = 1'b0;
            if (s_ff.rw) begin
              nxt_s.phase     = wpt_pkg::ST_TX;
              nxt_s.txShift   = 8'h00;
              nxt_s.sdaOe     = 1'b1;
              nxt_s.readArmed = 1'b0;
              if (!s_ff.readArmed) begin
                nxt_s.txData = 8'h00;
              end
            end else begin
              nxt_s.phase = wpt_pkg::ST_RX;
              nxt_s.sdaOe = 1'b0;
            end
          end
        end
        wpt_pkg::ST_WACK: begin
          if (sclFall) begin
            nxt_s.sdaOe  = 1'b0;
            nxt_s.bitCnt = 4'h0;
            nxt_s.phase  = (s_ff.busyCnt != '0) ? wpt_pkg::ST_IGNORE : wpt_pkg::ST_RX;
          end
        end
        wpt_pkg::ST_TX_LOAD: begin
          if (sclFall) begin
            nxt_s.txShift = s_ff.txData;
            nxt_s.sdaOe   = ~s_ff.txData[7];
            nxt_s.phase   = wpt_pkg::ST_TX;
            nxt_s.bitCnt  = 4'h0;
          end
        end
        wpt_pkg::ST_TX: begin
          if (sclRise) begin
            nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (s_ff.bitCnt == wpt_pkg::BITS_PER_BYTE) begin
              nxt_s.phase = wpt_pkg::ST_TACK;
              nxt_s.sdaOe = 1'b0;
            end else begin
              nxt_s.sdaOe   = ~s_ff.txShift[6];
              nxt_s.txShift = {s_ff.txShift[6:0], 1'b0};
            end
          end
        end
        wpt_pkg::ST_TACK: begin
          if (sclRise) begin
            if (!sdaS && !s_ff.byteIdx) begin
              nxt_s.phase   = wpt_pkg::ST_TX_LOAD;
              nxt_s.byteIdx = 1'b1;
            end else begin
              nxt_s.phase = wpt_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          nxt_s.phase = wpt_pkg::ST_IDLE;
          nxt_s.sdaOe = 1'b0;
        end
      endcase
    end
    if (exec) begin
      unique case (cmd)
        wpt_pkg::CMD_NOP, wpt_pkg::CMD_UNUSED: begin
        end
        wpt_pkg::CMD_STORE: begin
          nxt_s.eeprom  = s_ff.wiper;
          nxt_s.busyCnt = BUSY_W_CAST(STORE_CYC);
        end
        wpt_pkg::CMD_LOAD: begin
          nxt_s.wiper = s_ff.shift & MASK;
        end
        wpt_pkg::CMD_SHUT: begin
          nxt_s.shutdown = s_ff.shift[0];
        end
        wpt_pkg::CMD_RESET: begin
          nxt_s.refreshCnt = wpt_pkg::REF_W'(wpt_pkg::REFRESH_CYC);
        end
        wpt_pkg::CMD_RD_WIPER: begin
          nxt_s.txData    = s_ff.wiper & MASK;
          nxt_s.readArmed = 1'b1;
        end
        wpt_pkg::CMD_RD_EE: begin
          nxt_s.readArmed = 1'b1;
          if (s_ff.shift[1:0] == wpt_pkg::EE_SEL_WIPER) begin
            nxt_s.txData = s_ff.eeprom & MASK;
          end else if (s_ff.shift[1:0] == wpt_pkg::EE_SEL_TOL) begin
            nxt_s.txData = TOLERANCE;
          end else begin
            nxt_s.txData = 8'h00;
          end
        end
      endcase
    end
    nxt_s.busy = (nxt_s.busyCnt != '0);
  end

  function automatic logic [wpt_pkg::BUSY_W-1:0] BUSY_W_CAST(input int v);
    return wpt_pkg::BUSY_W'(v);
  endfunction : BUSY_W_CAST

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_ff        <= '0;
      s_ff.sclP   <= 3'h7;
      s_ff.sdaP   <= 3'h7;
      s_ff.eeprom <= wpt_pkg::MIDSCALE;
      s_ff.preset <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sdaOut       = s_ff.sdaOut;
  assign sdaOe        = s_ff.sdaOe;
  assign wiperSetting = s_ff.wiper;
  assign shutdownMode = s_ff.shutdown;
  assign eepromBusy   = s_ff.busy;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync_n);

  AST_ACK_ON_MATCH: assert property (s_ff.phase == wpt_pkg::ST_ADDR && sclFall && s_ff.bitCnt == 4'h8 &&
    s_ff.shift[7:1] == OWN_ADR && !s_ff.busy |=> s_ff.sdaOe && s_ff.phase == wpt_pkg::ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  AST_NO_ACK_OTHER: assert property (s_ff.phase == wpt_pkg::ST_ADDR && sclFall && s_ff.bitCnt == 4'h8 &&
    s_ff.shift[7:1] != OWN_ADR |=> !s_ff.sdaOe ##1 !s_ff.sdaOe)
    else $error("foreign address acknowledged");
  AST_LOCKED: assert property (s_ff.phase == wpt_pkg::ST_ADDR && sclFall && s_ff.bitCnt == 4'h8 &&
    s_ff.busy |=> s_ff.phase == wpt_pkg::ST_IGNORE && !s_ff.sdaOe)
    else $error("address acknowledged during store");
  AST_LOAD: assert property (exec && cmd == wpt_pkg::CMD_LOAD |=> wiperSetting == ($past(s_ff.shift) & MASK))
    else $error("wiper not loaded");
  AST_SHUT: assert property (exec && cmd == wpt_pkg::CMD_SHUT |=> shutdownMode == $past(s_ff.shift[0]))
    else $error("shutdown not updated");
  AST_STORE: assert property (exec && cmd == wpt_pkg::CMD_STORE |=> eepromBusy && s_ff.eeprom == $past(s_ff.wiper))
    else $error("store did not start");
  AST_NACK_RELEASE: assert property (s_ff.phase == wpt_pkg::ST_TACK && sclRise && sdaS && !startCond &&
    !stopCond |=> s_ff.phase == wpt_pkg::ST_IGNORE && !s_ff.sdaOe)
    else $error("second byte after NACK");
  AST_SDA_SCL_LOW: assert property ($rose(s_ff.sdaOe) |-> !s_ff.sclP[1] && !s_ff.sclP[2])
    else $error("SDA driven while SCL high");
  AST_DISARM: assert property (s_ff.phase == wpt_pkg::ST_ADDR_ACK && sclFall && s_ff.rw && !startCond &&
    !stopCond |=> !s_ff.readArmed)
    else $error("readback stays armed");
  AST_REFRESH: assert property (exec && cmd == wpt_pkg::CMD_RESET && !s_ff.preset |->
    ##[1:520] wiperSetting == (s_ff.eeprom & MASK))
    else $error("reset did not refresh wiper");

  COV_WRITE: cover property (exec && cmd == wpt_pkg::CMD_LOAD);
  COV_STORE: cover property (exec && cmd == wpt_pkg::CMD_STORE);
  COV_READ2: cover property (s_ff.phase == wpt_pkg::ST_TX && s_ff.byteIdx && s_ff.bitCnt == 4'h8);
  COV_NACK:  cover property (s_ff.phase == wpt_pkg::ST_TACK && sclRise && sdaS && !s_ff.byteIdx);
endmodule : wpt_i2c_target

`default_nettype wire

//--- src/wpt_pkg.sv
/*
  Shared constants, types and helpers for the I2C wiper command target.
  Assumes a 50 ns system clock; timing counts derive from that period.
*/
package wpt_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_NS      = 50;
  localparam int STORE_NS    = 18_000_000;
  localparam int STORE_CYC   = STORE_NS / CLK_NS;
  localparam int REFRESH_NS  = 25_000;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  localparam int BUSY_W      = 19;
  localparam int REF_W       = 10;

  // ==========================================================================
  // Addresses, reset values, codes
  localparam logic [6:0] ADDR_OPT0     = 7'h2f;
  localparam logic [6:0] ADDR_OPT1     = 7'h2c;
  localparam logic [7:0] MIDSCALE      = 8'h40;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] CMD_NOP       = 3'h0;
  localparam logic [2:0] CMD_STORE     = 3'h1;
  localparam logic [2:0] CMD_LOAD      = 3'h2;
  localparam logic [2:0] CMD_SHUT      = 3'h3;
  localparam logic [2:0] CMD_RESET     = 3'h4;
  localparam logic [2:0] CMD_RD_WIPER  = 3'h5;
  localparam logic [2:0] CMD_RD_EE     = 3'h6;
  localparam logic [2:0] CMD_UNUSED    = 3'h7;
  localparam logic [1:0] EE_SEL_WIPER  = 2'h0;
  localparam logic [1:0] EE_SEL_TOL    = 2'h1;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_WACK, ST_TX_LOAD, ST_TX, ST_TACK, ST_IGNORE}
    wpt_phase_t;

  typedef struct packed {
    logic [2:0]        sclP;
    logic [2:0]        sdaP;
    wpt_phase_t        phase;
    logic [3:0]        bitCnt;
    logic [7:0]        shift;
    logic              rw;
    logic              byteIdx;
    logic [7:0]        cmdHi;
    logic [7:0]        txShift;
    logic [7:0]        txData;
    logic              readArmed;
    logic [7:0]        wiper;
    logic [7:0]        eeprom;
    logic              shutdown;
    logic [BUSY_W-1:0] busyCnt;
    logic              busy;
    logic [REF_W-1:0]  refreshCnt;
    logic              preset;
    logic              sdaOe;
    logic              sdaOut;
  } wpt_state_t;

  // Bits of the wiper word that a variant keeps
  function automatic logic [7:0] wpt_mask(input int positions);
    if (positions == 32) return 8'hfc;
    if (positions == 64) return 8'hfe;
    return 8'hff;
  endfunction : wpt_mask
endpackage : wpt_pkg

//--- verif/wpt_i2c_ctrl.sv
/*
  I2C bus controller model: drives SCL and pulls SDA low when asked.
  Assumes the bench resolves SDA with a pull-up; steps on sys_clk falls.
*/
`timescale 1ns/10ps
`default_nettype none

module wpt_i2c_ctrl (
  input  wire logic sys_clk,
  input  wire logic sdaWire,
  output var logic  sclOut,
  output var logic  sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic hc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hc

  // ==========================================================================
  // Bus conditions
  task automatic start();
    sdaLow = 1'b0;
    hc(2);
    sclOut = 1'b1;
    hc(4);
    sdaLow = 1'b1;
    hc(4);
    sclOut = 1'b0;
    hc(2);
  endtask : start

  task automatic stop();
    sdaLow = 1'b1;
    hc(2);
    sclOut = 1'b1;
    hc(4);
    sdaLow = 1'b0;
    hc(8);
  endtask : stop

  // ==========================================================================
  // Bits and bytes; SCL half period is 4 system clocks
  task automatic bit_io(input logic b, output logic r);
    sdaLow = ~b;
    hc(2);
    sclOut = 1'b1;
    hc(2);
    r = sdaWire;
    hc(2);
    sclOut = 1'b0;
    hc(2);
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ackIt, r);
  endtask : rd_byte
endmodule : wpt_i2c_ctrl

`default_nettype wire

//--- verif/wpt_i2c_target_tb.sv
/*
  Self-checking bench of the wiper command target: command words and readback.
  Assumes a pulled-up SDA, a 64-position build at the second address option.
*/
`timescale 1ns/10ps
`default_nettype none

module wpt_i2c_target_tb;
  localparam logic [6:0] ADDR = wpt_pkg::ADDR_OPT1;
  localparam logic [7:0] TOL  = 8'h5a; // Arbitrary tolerance code
  logic       sys_clk;
  logic       rst_n;
  logic       sclOut;
  logic       sdaLow;
  logic       sdaWire;
  logic       sdaOut;
  logic       sdaOe;
  logic       shutdownMode;
  logic       eepromBusy;
  logic [7:0] wiperSetting;
  logic [7:0] d;
  logic       a;
  int         fails;
  int         checks;

  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;

  wpt_i2c_target #(.POSITIONS(64), .ADDR_SEL(1'b1), .STORE_CYC(200), .TOLERANCE(TOL)) u_wpt_i2c_target (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .wiperSetting(wiperSetting), .shutdownMode(shutdownMode), .eepromBusy(eepromBusy));

  wpt_i2c_ctrl u_wpt_i2c_ctrl (.sys_clk(sys_clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaLow(sdaLow));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Compare and closing
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic end_sim();
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Transfers
  task automatic probe(input logic [7:0] ab, input logic exp);
    u_wpt_i2c_ctrl.start();
    u_wpt_i2c_ctrl.wr_byte(ab, a);
    chk8({7'h0, a}, {7'h0, exp});
    u_wpt_i2c_ctrl.stop();
  endtask : probe

  task automatic wr_pair(input logic [7:0] hi, input logic [7:0] lo);
    u_wpt_i2c_ctrl.wr_byte(hi, a);
    chk8({7'h0, a}, 8'h01);
    u_wpt_i2c_ctrl.wr_byte(lo, a);
    chk8({7'h0, a}, 8'h01);
  endtask : wr_pair

  task automatic wr1(input logic [7:0] hi, input logic [7:0] lo);
    u_wpt_i2c_ctrl.start();
    u_wpt_i2c_ctrl.wr_byte({ADDR, 1'b0}, a);
    chk8({7'h0, a}, 8'h01);
    wr_pair(hi, lo);
    u_wpt_i2c_ctrl.stop();
  endtask : wr1

  task automatic rd_word(input logic [7:0] hi, input logic [7:0] lo);
    u_wpt_i2c_ctrl.start();
    u_wpt_i2c_ctrl.wr_byte({ADDR, 1'b1}, a);
    chk8({7'h0, a}, 8'h01);
    u_wpt_i2c_ctrl.rd_byte(1'b1, d);
    chk8(d, hi);
    u_wpt_i2c_ctrl.rd_byte(1'b0, d);
    chk8(d, lo);
    u_wpt_i2c_ctrl.stop();
  endtask : rd_word

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n  = 1'b0;
    fails  = 0;
    checks = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    run_tests();
    end_sim();
  end

  task automatic run_tests();
    chk8(wiperSetting, wpt_pkg::MIDSCALE & 8'hfe);
    probe({wpt_pkg::ADDR_OPT0, 1'b0}, 1'b0);
    probe(8'h00, 1'b0);
    probe(8'hf0, 1'b0);
    wr1(8'hfa, 8'h81);
    chk8(wiperSetting, 8'h80);
    u_wpt_i2c_ctrl.start();
    u_wpt_i2c_ctrl.wr_byte({ADDR, 1'b0}, a);
    wr_pair(8'h02, 8'hff);
    wr_pair(8'h03, 8'h01);
    u_wpt_i2c_ctrl.stop();
    chk8(wiperSetting, 8'hfe);
    chk8({7'h0, shutdownMode}, 8'h01);
    wr1(8'h03, 8'hfe);
    chk8({7'h0, shutdownMode}, 8'h00);
    wr1(8'h07, 8'h10);
    wr1(8'h00, 8'h10);
    chk8(wiperSetting, 8'hfe);
    wr1(8'h05, 8'h00);
    rd_word(8'h00, 8'hfe);
    rd_word(8'h00, 8'h00);
    wr1(8'h02, 8'h23);
    wr1(8'h01, 8'h00);
    chk8({7'h0, eepromBusy}, 8'h01);
    probe({ADDR, 1'b0}, 1'b0);
    for (int i = 0; i <= 8; i++) begin
      if (i == 8) begin
        chk8({7'h0, a}, 8'h01);
        return;
      end
      u_wpt_i2c_ctrl.start();
      u_wpt_i2c_ctrl.wr_byte({ADDR, 1'b0}, a);
      u_wpt_i2c_ctrl.stop();
      if (a === 1'b1) break;
    end
    chk8({7'h0, eepromBusy}, 8'h00);
    wr1(8'h02, 8'h00);
    wr1(8'h04, 8'h00);
    for (int i = 0; i < 700 && wiperSetting !== 8'h22; i++) @(negedge sys_clk);
    chk8(wiperSetting, 8'h22);
    if (wiperSetting !== 8'h22) return;
    wr1(8'h06, 8'h00);
    rd_word(8'h00, 8'h22);
    wr1(8'h06, 8'h01);
    rd_word(8'h00, TOL);
    wr1(8'h06, 8'h02);
    rd_word(8'h00, 8'h00);
    wr1(8'h05, 8'h00);
    u_wpt_i2c_ctrl.start();
    u_wpt_i2c_ctrl.wr_byte({ADDR, 1'b1}, a);
    u_wpt_i2c_ctrl.rd_byte(1'b0, d);
    chk8(d, 8'h00);
    u_wpt_i2c_ctrl.rd_byte(1'b0, d);
    chk8(d, 8'hff);
    u_wpt_i2c_ctrl.stop();
  endtask : run_tests
endmodule : wpt_i2c_target_tb

`default_nettype wire
